// *** logic/rmpc_defs.vh ***
`ifndef RMPC_DEFS_VH
`define RMPC_DEFS_VH

// ----------------------------------------------------------------
// binary command codes
// ----------------------------------------------------------------
`define RMPC_CODE_MAX_PKT      8'h29
`define RMPC_CODE_PKT_THRESH   8'h20
`define RMPC_CODE_PKT_TIMEOUT  8'h21
`define RMPC_CODE_SLEEP_MODE   8'h01
`define RMPC_CODE_IDLE_SLEEP   8'h02
`define RMPC_CODE_STREAM_LIM   8'h1A
`define RMPC_CODE_PWM_TIMER    8'h22
`define RMPC_CODE_VOLTAGE      8'h3B

// ----------------------------------------------------------------
// query-only codes, no binary command of their own
// ----------------------------------------------------------------
`define RMPC_CODE_AMB_ONE      8'h80
`define RMPC_CODE_AMB_ALL      8'h81
`define RMPC_CODE_FW_TEXT      8'h82

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RMPC_RST_MAX_PKT       16'h0800
`define RMPC_RST_PKT_THRESH    16'h0800
`define RMPC_RST_PKT_TIMEOUT   16'h0003
`define RMPC_RST_SLEEP_MODE    16'h0000
`define RMPC_RST_IDLE_SLEEP    16'h0064
`define RMPC_RST_STREAM_LIM    16'h0000
`define RMPC_RST_PWM_TIMER     16'h0020

// ----------------------------------------------------------------
// legal ranges
// ----------------------------------------------------------------
`define RMPC_MAX_PKT_HI        16'h0800
`define RMPC_SLEEP_MODE_HI     16'h0008
`define RMPC_SLEEP_MODE_RSVD   16'h0003
`define RMPC_IDLE_SLEEP_HI     16'h7FFF
`define RMPC_IDLE_SLEEP_ADD    16'h0003
`define RMPC_PWM_TIMER_HI      16'h00FF
`define RMPC_AMB_ONE_HI        8'h31
`define RMPC_AMB_ALL_HI        16'h07D0

// ----------------------------------------------------------------
// number base and reply lengths in bytes
// ----------------------------------------------------------------
`define RMPC_BASE_DEC          2'h0
`define RMPC_BASE_HEX          2'h1
`define RMPC_LEN_ONE           4'h1
`define RMPC_LEN_TWO           4'h2
`define RMPC_LEN_FOUR          4'h4
`define RMPC_LEN_VOLT_TEXT     4'h6
`define RMPC_LEN_FW_TEXT       4'h8

`endif

// *** logic/rmpc_param_cmd.v ***
// Behaviour
// (R1) default number base means hexadecimal numbers
// (R2) max packet size 0x29, 1..0x800, 2 bytes
// (R3) threshold 0x20, 1..stored max, reset 0x800
// (R4) timeout 0x21, 0..0xFFFF, default 3
// (R5) sleep mode 0x01, 0..8, 3 reserved
// (R6) idle time 0x02, guard+3..0x7FFF, default 0x64
// (R7) streaming limit 0x1A, zero disables, default 0
// (R8) pwm timer 0x22, 0..0xFF, default 0x20
// (R9) single-channel ambient power read-only, one byte
// (R10) all-channel ambient power returns two bytes
// (R11) firmware version query answers a text string
// (R12) voltage decimal text base 0, hex base 1
// (R13) reads return listed byte count, MSB first
// (R14) out-of-range writes rejected, value kept
`timescale 1ns/100ps
`default_nettype none
`include "rmpc_defs.vh"

module rmpc_param_cmd #(
   parameter [63:0] FW_TEXT = 64'h7665725F315F3030
) (
   input wire mclk,
   input wire arst_n,
   input wire cmd_valid,
   input wire cmd_write,
   input wire [7:0] cmd_code,
   input wire [15:0] cmd_value,
   output wire cmd_ready,
   output reg cmd_done,
   output reg cmd_error,
   input wire [1:0] number_base,
   input wire [15:0] guard_time_after,
   input wire [7:0] ambient_one,
   input wire [15:0] ambient_all,
   input wire [31:0] board_voltage,
   output wire resp_valid,
   input wire resp_ready,
   output wire [7:0] resp_data,
   output wire resp_last,
   output wire resp_text,
   output reg [15:0] max_radio_packet_size,
   output reg [15:0] packetization_threshold,
   output reg [15:0] packetization_timeout,
   output reg [3:0] sleep_mode_select,
   output reg [15:0] idle_time_before_sleep,
   output reg [15:0] streaming_limit,
   output wire streaming_limit_on,
   output reg [7:0] signal_pwm_timer
);

   // ----------------------------------------------------------------
   // reply shift buffer
   // ----------------------------------------------------------------
   reg [63:0] resp_buf;
   reg [3:0] resp_len;
   reg resp_is_text;
   reg [63:0] next_buf;
   reg [3:0] next_len;
   reg next_text;
   reg next_err;
   reg wr_ok;

   localparam [15:0] RST_SLEEP = `RMPC_RST_SLEEP_MODE;
   localparam [15:0] RST_PWM = `RMPC_RST_PWM_TIMER;

   wire take = cmd_valid & cmd_ready;

   assign cmd_ready = (resp_len == 4'h0);
   assign resp_valid = (resp_len != 4'h0);
   assign resp_data = resp_buf[63:56]; // R13
   assign resp_last = (resp_len == 4'h1);
   assign resp_text = resp_is_text;
   assign streaming_limit_on = (streaming_limit != 16'h0000); // R7

   // ----------------------------------------------------------------
   // decimal rendering of the board voltage
   // ----------------------------------------------------------------
   wire [38:0] volt_prod = board_voltage * 39'd100;
   wire [9:0] volt_hund = volt_prod[25:16];
   wire [9:0] volt_int = volt_hund / 10'd100;
   wire [9:0] volt_rem = volt_hund - volt_int * 10'd100;
   wire [9:0] volt_ten = volt_rem / 10'd10;
   wire [9:0] volt_one = volt_rem - volt_ten * 10'd10;
   wire [47:0] volt_text = {
      8'h30 + {4'h0, volt_int[3:0]}, 8'h2E,
      8'h30 + {4'h0, volt_ten[3:0]}, 8'h30 + {4'h0, volt_one[3:0]},
      8'h20, 8'h56};

   wire [15:0] idle_lo = guard_time_after + `RMPC_IDLE_SLEEP_ADD;
   wire [7:0] amb_one_cl = (ambient_one > `RMPC_AMB_ONE_HI) ? `RMPC_AMB_ONE_HI : ambient_one;
   wire [15:0] amb_all_cl = (ambient_all > `RMPC_AMB_ALL_HI) ? `RMPC_AMB_ALL_HI : ambient_all;

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   always @* begin
      next_buf = 64'h0;
      next_len = 4'h0;
      next_text = 1'b0;
      next_err = 1'b0;
      wr_ok = 1'b0;
      case (cmd_code)
         `RMPC_CODE_MAX_PKT: begin
            wr_ok = (cmd_value >= 16'h0001) && (cmd_value <= `RMPC_MAX_PKT_HI); // R2
            next_buf = {max_radio_packet_size, 48'h0};
            next_len = `RMPC_LEN_TWO; // R2
         end
         `RMPC_CODE_PKT_THRESH: begin
            wr_ok = (cmd_value >= 16'h0001) && (cmd_value <= max_radio_packet_size); // R3
            next_buf = {packetization_threshold, 48'h0};
            next_len = `RMPC_LEN_TWO;
         end
         `RMPC_CODE_PKT_TIMEOUT: begin
            wr_ok = 1'b1; // R4
            next_buf = {packetization_timeout, 48'h0};
            next_len = `RMPC_LEN_TWO;
         end
         `RMPC_CODE_SLEEP_MODE: begin
            wr_ok = (cmd_value <= `RMPC_SLEEP_MODE_HI) &&
                    (cmd_value != `RMPC_SLEEP_MODE_RSVD); // R5
            next_buf = {4'h0, sleep_mode_select, 56'h0};
            next_len = `RMPC_LEN_ONE;
         end
         `RMPC_CODE_IDLE_SLEEP: begin
            wr_ok = (cmd_value >= idle_lo) && (cmd_value <= `RMPC_IDLE_SLEEP_HI); // R6
            next_buf = {idle_time_before_sleep, 48'h0};
            next_len = `RMPC_LEN_TWO;
         end
         `RMPC_CODE_STREAM_LIM: begin
            wr_ok = 1'b1; // R7
            next_buf = {streaming_limit, 48'h0};
            next_len = `RMPC_LEN_TWO;
         end
         `RMPC_CODE_PWM_TIMER: begin
            wr_ok = (cmd_value <= `RMPC_PWM_TIMER_HI); // R8
            next_buf = {signal_pwm_timer, 56'h0};
            next_len = `RMPC_LEN_ONE;
         end
         `RMPC_CODE_AMB_ONE: begin
            next_buf = {amb_one_cl, 56'h0}; // R9
            next_len = `RMPC_LEN_ONE;
         end
         `RMPC_CODE_AMB_ALL: begin
            next_buf = {amb_all_cl, 48'h0}; // R10
            next_len = `RMPC_LEN_TWO;
         end
         `RMPC_CODE_FW_TEXT: begin
            next_buf = FW_TEXT; // R11
            next_len = `RMPC_LEN_FW_TEXT;
            next_text = 1'b1;
         end
         `RMPC_CODE_VOLTAGE: begin
            if (number_base == `RMPC_BASE_DEC) begin
               next_buf = {volt_text, 16'h0}; // R12
               next_len = `RMPC_LEN_VOLT_TEXT;
               next_text = 1'b1;
            end else begin // R1
               next_buf = {board_voltage, 32'h0}; // R12
               next_len = `RMPC_LEN_FOUR;
            end
         end
         default: begin
            next_err = 1'b1;
         end
      endcase
      if (cmd_write) begin
         next_len = 4'h0;
         next_text = 1'b0;
         if (!wr_ok) begin
            next_err = 1'b1; // R14
         end
      end
   end

   // ----------------------------------------------------------------
   // parameter store
   // ----------------------------------------------------------------
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         max_radio_packet_size <= `RMPC_RST_MAX_PKT;
         packetization_threshold <= `RMPC_RST_PKT_THRESH; // R3
         packetization_timeout <= `RMPC_RST_PKT_TIMEOUT; // R4
         sleep_mode_select <= RST_SLEEP[3:0]; // R5
         idle_time_before_sleep <= `RMPC_RST_IDLE_SLEEP; // R6
         streaming_limit <= `RMPC_RST_STREAM_LIM; // R7
         signal_pwm_timer <= RST_PWM[7:0]; // R8
      end else if (take && cmd_write && wr_ok) begin // R14
         case (cmd_code)
            `RMPC_CODE_MAX_PKT: begin
               max_radio_packet_size <= cmd_value;
            end
            `RMPC_CODE_PKT_THRESH: begin
               packetization_threshold <= cmd_value;
            end
            `RMPC_CODE_PKT_TIMEOUT: begin
               packetization_timeout <= cmd_value;
            end
            `RMPC_CODE_SLEEP_MODE: begin
               sleep_mode_select <= cmd_value[3:0];
            end
            `RMPC_CODE_IDLE_SLEEP: begin
               idle_time_before_sleep <= cmd_value;
            end
            `RMPC_CODE_STREAM_LIM: begin
               streaming_limit <= cmd_value;
            end
            `RMPC_CODE_PWM_TIMER: begin
               signal_pwm_timer <= cmd_value[7:0];
            end
            default: begin
               signal_pwm_timer <= signal_pwm_timer;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // reply sequencing and status pulses
   // ----------------------------------------------------------------
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         resp_buf <= 64'h0;
         resp_len <= 4'h0;
         resp_is_text <= 1'b0;
         cmd_done <= 1'b0;
         cmd_error <= 1'b0;
      end else begin
         cmd_done <= take;
         cmd_error <= take & next_err;
         if (take) begin
            resp_buf <= next_err ? 64'h0 : next_buf;
            resp_len <= next_err ? 4'h0 : next_len; // R13
            resp_is_text <= next_text & ~next_err;
         end else if (resp_valid && resp_ready) begin
            resp_buf <= {resp_buf[55:0], 8'h00}; // R13
            resp_len <= resp_len - 4'h1;
         end
      end
   end

endmodule // rmpc_param_cmd
`default_nettype wire

// *** verif/rmpc_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module rmpc_checker (
   input wire mclk,
   input wire arst_n,
   input wire cmd_valid,
   input wire cmd_write,
   input wire [7:0] cmd_code,
   input wire [15:0] cmd_value,
   input wire cmd_ready,
   input wire cmd_done,
   input wire cmd_error,
   input wire resp_valid,
   input wire [15:0] max_radio_packet_size,
   input wire [15:0] packetization_threshold,
   input wire [3:0] sleep_mode_select,
   input wire [15:0] idle_time_before_sleep,
   input wire [15:0] streaming_limit,
   input wire streaming_limit_on
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // ----------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------
   sequence s_take;
      cmd_valid && cmd_ready;
   endsequence
   sequence s_rd_pkt;
      cmd_valid && cmd_ready && !cmd_write && cmd_code == 8'h29;
   endsequence
   sequence s_bad_pkt;
      cmd_valid && cmd_ready && cmd_write && cmd_code == 8'h29 &&
         (cmd_value == 16'h0000 || cmd_value > 16'h0800);
   endsequence
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   chk_done_after_take: assert property (s_take |=> cmd_done)
      else $error("no done after take");
   chk_read_reply: assert property (s_rd_pkt |=> resp_valid && !cmd_ready)
      else $error("no reply after read");
   chk_reject_keep: assert property (s_bad_pkt |=> cmd_error && $stable(max_radio_packet_size))
      else $error("bad write not refused");
   chk_error_done: assert property (cmd_error |-> cmd_done)
      else $error("error without done");
   chk_pkt_range: assert property (max_radio_packet_size >= 16'h0001 &&
      max_radio_packet_size <= 16'h0800)
      else $error("packet size out of range");
   chk_thresh_low: assert property (packetization_threshold != 16'h0000)
      else $error("threshold zero");
   chk_sleep_legal: assert property (sleep_mode_select <= 4'h8 && sleep_mode_select != 4'h3)
      else $error("sleep mode illegal");
   chk_idle_max: assert property (idle_time_before_sleep <= 16'h7FFF)
      else $error("idle time above limit");
   chk_stream_on: assert property (streaming_limit_on == (streaming_limit != 16'h0000))
      else $error("limit enable wrong");
endmodule // rmpc_checker
bind rmpc_param_cmd rmpc_checker chk_u (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid),
   .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_value(cmd_value), .cmd_ready(cmd_ready),
   .cmd_done(cmd_done), .cmd_error(cmd_error), .resp_valid(resp_valid),
   .max_radio_packet_size(max_radio_packet_size),
   .packetization_threshold(packetization_threshold), .sleep_mode_select(sleep_mode_select),
   .idle_time_before_sleep(idle_time_before_sleep), .streaming_limit(streaming_limit),
   .streaming_limit_on(streaming_limit_on));
`default_nettype wire

// *** verif/rmpc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module rmpc_host_model (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic stall,
   output var logic resp_ready
);
   // consumer takes reply bytes, every other cycle when stalling
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) resp_ready <= 1'b0;
      else resp_ready <= stall ? ~resp_ready : 1'b1;
   end
endmodule // rmpc_host_model
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
   logic mclk = 0, arst_n = 0, cmd_valid = 0, cmd_write = 0, resp_ready, stall = 0;
   logic [7:0] cmd_code = 8'h00, ambient_one = 8'h40, resp_data;
   logic [15:0] cmd_value = 16'h0000, guard_time_after = 16'h0010, ambient_all = 16'h0123;
   logic [1:0] number_base = 2'h1;
   logic [31:0] board_voltage = 32'h0005051F;
   wire cmd_ready, cmd_done, cmd_error, resp_valid, resp_last, resp_text, lim_on;
   wire [15:0] pkt, thr, tmo, idle, lim;
   wire [3:0] slp;
   wire [7:0] pwm;
   int fail_count = 0, checked = 0, cyc = 0;
   localparam [63:0] FW = 64'h666972775F305F31; // arbitrary text
   rmpc_param_cmd #(.FW_TEXT(FW)) dut_u (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_value(cmd_value), .cmd_ready(cmd_ready),
      .cmd_done(cmd_done), .cmd_error(cmd_error), .number_base(number_base),
      .guard_time_after(guard_time_after), .ambient_one(ambient_one), .ambient_all(ambient_all),
      .board_voltage(board_voltage), .resp_valid(resp_valid), .resp_ready(resp_ready),
      .resp_data(resp_data), .resp_last(resp_last), .resp_text(resp_text),
      .max_radio_packet_size(pkt), .packetization_threshold(thr), .packetization_timeout(tmo),
      .sleep_mode_select(slp), .idle_time_before_sleep(idle), .streaming_limit(lim),
      .streaming_limit_on(lim_on), .signal_pwm_timer(pwm));
   rmpc_host_model host_u (.mclk(mclk), .arst_n(arst_n), .stall(stall), .resp_ready(resp_ready));
   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         close_out;
      end
   end
   task close_out;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // command and reply helpers
   // ----------------------------------------------------------------
   task op(input logic w, input logic [7:0] c, input logic [15:0] v, input logic er);
      cmd_write = w;
      cmd_code = c;
      cmd_value = v;
      cmd_valid = 1;
      @(posedge mclk);
      #2;
      `CHK("done", 1'b1, cmd_done)
      `CHK("error", er, cmd_error)
   endtask
   task rd(input logic [7:0] c, input logic [3:0] n, input logic [63:0] e, input logic t);
      logic [63:0] acc;
      logic [3:0] k;
      logic dn, tx;
      op(0, c, 16'h0000, 1'b0);
      `CHK("busy", 1'b0, cmd_ready)
      cmd_valid = 0;
      acc = 0;
      k = 0;
      dn = 0;
      tx = 0;
      for (int i = 0; i < 40 && !dn; i++) begin
         if (resp_valid === 1'b1 && resp_ready === 1'b1) begin
            acc = {acc[55:0], resp_data};
            k++;
            dn = (resp_last === 1'b1);
            tx = resp_text;
         end
         @(posedge mclk);
         #2;
      end
      `CHK("idle ready", 1'b1, cmd_ready)
      `CHK("reply length", n, k)
      `CHK("reply bytes", e, acc)
      `CHK("reply text", t, tx)
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_defaults;
      `CHK("defaults", {16'h0800, 16'h0800, 16'h0003, 16'h0064}, {pkt, thr, tmo, idle})
      `CHK("lim default", 17'h00000, {lim, lim_on})
      rd(8'h29, 4'h2, 64'h0800, 1'b0);
      rd(8'h21, 4'h2, 64'h0003, 1'b0);
      rd(8'h01, 4'h1, 64'h00, 1'b0);
      rd(8'h22, 4'h1, 64'h20, 1'b0);
   endtask
   task t_limits;
      op(1, 8'h29, 16'h0000, 1'b1);
      op(1, 8'h29, 16'h0801, 1'b1);
      op(1, 8'h29, 16'h0400, 1'b0);
      op(1, 8'h20, 16'h0401, 1'b1);
      op(1, 8'h20, 16'h0000, 1'b1);
      op(1, 8'h20, 16'h0400, 1'b0);
      op(1, 8'h01, 16'h0003, 1'b1);
      op(1, 8'h01, 16'h0009, 1'b1);
      op(1, 8'h01, 16'h0008, 1'b0);
      op(1, 8'h02, 16'h0012, 1'b1);
      op(1, 8'h02, 16'h8000, 1'b1);
      op(1, 8'h02, 16'h0013, 1'b0);
      guard_time_after = 16'h0020;
      op(1, 8'h02, 16'h0022, 1'b1);
      op(1, 8'h1A, 16'h1234, 1'b0);
      op(1, 8'h22, 16'h0100, 1'b1);
      op(1, 8'h22, 16'h00FF, 1'b0);
      op(1, 8'h21, 16'hFFFF, 1'b0);
      op(1, 8'h55, 16'h0001, 1'b1);
      cmd_valid = 0;
      @(posedge mclk);
      #2;
      `CHK("stores", {16'h0400, 16'h0400, 16'hFFFF, 16'h0013}, {pkt, thr, tmo, idle})
      `CHK("sleep pwm", 12'h8FF, {slp, pwm})
      `CHK("limit", 17'h02469, {lim, lim_on})
      rd(8'h29, 4'h2, 64'h0400, 1'b0);
   endtask
   task t_queries;
      stall = 1;
      rd(8'h80, 4'h1, 64'h31, 1'b0);
      stall = 0;
      op(1, 8'h80, 16'h0001, 1'b1);
      cmd_valid = 0;
      @(posedge mclk);
      #2;
      rd(8'h81, 4'h2, 64'h0123, 1'b0);
      rd(8'h82, 4'h8, FW, 1'b1);
      rd(8'h3B, 4'h4, 64'h0005051F, 1'b0);
      number_base = 2'h0;
      rd(8'h3B, 4'h6, 64'h352E30322056, 1'b1);
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      #2 arst_n = 1;
      t_defaults;
      t_limits;
      t_queries;
      close_out;
   end
endmodule // tb
`default_nettype wire
